// file: rtl/fhp_pkg.sv
/*
 * Shared constants and carrier types for the formatter host port.
 * Assumes all host port pins are active low and that this package is
 * compiled before any design file that names it.
 */
package fhp_pkg;

    localparam int BUS_W = 8;
    localparam int NUM_DRIVES = 4;
    localparam int DRV_AW = 2;

    // Electrical levels on the host pins
    localparam logic LVL_TRUE = 1'b0;
    localparam logic LVL_FALSE = 1'b1;

    localparam logic [BUS_W-1:0] BUS_IDLE = 8'hFF;
    localparam logic [NUM_DRIVES-1:0] DRV_NONE = 4'hF;
    localparam logic [3:0] PIN_IN_IDLE = 4'hF;

    // Port sequencer states
    typedef enum logic [3:0] {
        ST_INIT = 4'h0,
        ST_IDLE = 4'h1,
        ST_CMD = 4'h2,
        ST_WR = 4'h3,
        ST_RD_SET = 4'h4,
        ST_RD_ACK = 4'h5,
        ST_RD_END = 4'h6,
        ST_ST_SET = 4'h7,
        ST_ST_RDY = 4'h8,
        ST_REQ_END = 4'h9
    } fhp_state_type;

    // Head recalibration states
    typedef enum logic [1:0] {
        RC_IDLE = 2'h0,
        RC_DOWN = 2'h1,
        RC_UP = 2'h2
    } fhp_recal_state_type;

    // Control lines from the host, all active low
    typedef struct packed {
        logic host_reset_b;
        logic host_online_b;
        logic request_b;
        logic host_data_strobe_b;
    } fhp_pin_in_type;

    // Control lines to the host, all active low
    typedef struct packed {
        logic ack_b;
        logic ready_b;
        logic fmt_exception_b;
        logic direction_b;
    } fhp_pin_out_type;

endpackage

// file: rtl/fhp_recal.sv
/*
 * Head recalibration sequencer: steps the head down to its lowest stop,
 * then back up to track 0.
 * Assumes the stop and track 0 sensors come straight from the mechanism
 * and are asynchronous to clk_sys.
 */
`timescale 1ns/10ps
module fhp_recal
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic start,
    input wire logic at_bottom_raw,
    input wire logic at_track0_raw,
    output logic step_down,
    output logic step_up,
    output logic busy
);

    logic [1:0] sens1_r;
    logic [1:0] sens2_r;
    fhp_pkg::fhp_recal_state_type rc_r;
    fhp_pkg::fhp_recal_state_type rc_nxt;

    // Sensors pass two flops before any decision reads them
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            sens1_r <= 2'h0;
            sens2_r <= 2'h0;
        end
        else
        begin
            sens1_r <= {at_bottom_raw, at_track0_raw};
            sens2_r <= sens1_r;
        end
    end

    // Down to the stop first, so the track count starts from a known place
    always_comb
    begin
        rc_nxt = rc_r;
        case (rc_r)
            fhp_pkg::RC_IDLE:
                if (start)
                    rc_nxt = fhp_pkg::RC_DOWN; // see R19
            fhp_pkg::RC_DOWN:
                if (sens2_r[1])
                    rc_nxt = fhp_pkg::RC_UP; // see R19
            fhp_pkg::RC_UP:
                if (sens2_r[0])
                    rc_nxt = fhp_pkg::RC_IDLE; // see R19
            default:
                rc_nxt = fhp_pkg::RC_IDLE;
        endcase
        if (start)
            rc_nxt = fhp_pkg::RC_DOWN; // A new reset restarts the motion
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
            rc_r <= fhp_pkg::RC_IDLE;
        else
            rc_r <= rc_nxt;
    end

    assign step_down = (rc_r == fhp_pkg::RC_DOWN);
    assign step_up = (rc_r == fhp_pkg::RC_UP);
    assign busy = (rc_r != fhp_pkg::RC_IDLE);

    a_recal_up_order: assert property (@(posedge clk_sys) disable iff (!rst_b) // see R19
        $rose(step_up) |-> $past(step_down) && $past(sens2_r[1]))
        else $error("head moved up before reaching the bottom stop");

    c_recal_done: cover property (@(posedge clk_sys) disable iff (!rst_b)
        $fell(step_up) && !busy);

endmodule

// file: rtl/fhp_host_port.sv
/*
 * Host side parallel port of a cartridge tape formatter: interlocked
 * command, status, write and read byte transfers over an 8-bit active low
 * bus, plus exception, drive select and the reset/recalibration sequence.
 * Assumes every host pin is asynchronous to clk_sys and that the formatter
 * core on the user side runs on clk_sys.
 */
// Overview of operation
// R01: All host port lines are low when true and high when idle.
// R02: One 8-bit two-way bus carries commands, status and data, bit 7 MSB.
// R03: Host holds online through a read or write; dropping it ends that command.
// R04: Host puts the command byte on the bus, then asserts request.
// R05: Host asserts request after capturing a status byte from the bus.
// R06: Host reset runs the same initialisation as power-on.
// R07: In a write, host asserts transfer once its data byte is on the bus.
// R08: In a read, host asserts transfer after capturing the presented byte.
// R09: Acknowledge follows capture of write data, or driving of read data.
// R10: Ready shows that the command byte has been captured.
// R11: Ready shows that a status byte is valid on the bus.
// R12: Ready marks command completion; when idle it means a command is accepted.
// R13: In write mode ready means a buffer is free or file mark allowed.
// R14: In read mode ready means a full buffer waits or file mark allowed.
// R15: Exception stays asserted while the condition exists; host reads status then.
// R16: Direction false: host drives the bus, formatter drivers are off.
// R17: Direction true: host drivers off, formatter drives the bus.
// R18: Up to four drives are served through one port.
// R19: Power-up or reset moves the head down, then up to track 0.
// R20: Each strobe holds until its answer, and both release before the next byte.
// R21: Spare and reserved lines are neither driven nor read.
`timescale 1ns/10ps
module fhp_host_port
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input fhp_pkg::fhp_pin_in_type pin_in,
    output fhp_pkg::fhp_pin_out_type pin_out,
    input wire logic [fhp_pkg::BUS_W-1:0] host_bus_in,
    output logic [fhp_pkg::BUS_W-1:0] host_bus_out,
    output logic host_bus_oe_b,
    output logic [fhp_pkg::BUS_W-1:0] cmd_byte,
    output logic cmd_valid,
    input wire logic cmd_accept,
    input wire logic cmd_done,
    input wire logic [fhp_pkg::BUS_W-1:0] stat_byte,
    input wire logic stat_valid,
    output logic stat_taken,
    input wire logic wr_mode,
    input wire logic buf_free,
    output logic [fhp_pkg::BUS_W-1:0] wr_byte,
    output logic wr_valid,
    input wire logic rd_mode,
    input wire logic buf_full,
    input wire logic [fhp_pkg::BUS_W-1:0] rd_byte,
    input wire logic rd_valid,
    output logic rd_taken,
    output logic rw_abort,
    input wire logic exc_cond,
    input wire logic [fhp_pkg::DRV_AW-1:0] drive_addr,
    output logic [fhp_pkg::NUM_DRIVES-1:0] drive_sel_b,
    output logic init_busy,
    input wire logic at_bottom_raw,
    input wire logic at_track0_raw,
    output logic step_down,
    output logic step_up
);

    fhp_pkg::fhp_pin_in_type pin1_r;
    fhp_pkg::fhp_pin_in_type pin2_r;
    fhp_pkg::fhp_pin_in_type pin3_r;
    logic [fhp_pkg::BUS_W-1:0] bus1_r;
    logic [fhp_pkg::BUS_W-1:0] bus2_r;
    logic hr_act, on_act, req_act, stb_act, on_fell;

    fhp_pkg::fhp_state_type st_r, st_nxt;
    logic ready_r, ready_nxt, ack_r, ack_nxt, dir_r, dir_nxt;
    logic [fhp_pkg::BUS_W-1:0] bus_out_r, bus_out_nxt;
    logic [fhp_pkg::BUS_W-1:0] cmd_byte_r, cmd_byte_nxt, wr_byte_r, wr_byte_nxt;
    logic cmd_valid_r, cmd_valid_nxt, wr_valid_r, wr_valid_nxt;
    logic stat_taken_r, stat_taken_nxt, rd_taken_r, rd_taken_nxt;
    logic abort_r, abort_nxt, done_r, done_nxt, start_r, start_nxt;
    logic exc_r, exc_nxt, idle_rdy, recal_busy;
    logic [fhp_pkg::NUM_DRIVES-1:0] drv_r, drv_nxt;

    // Pins pass two flops; a third copy only feeds edge detection; spare lines have no port (see R21)
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            pin1_r <= fhp_pkg::PIN_IN_IDLE;
            pin2_r <= fhp_pkg::PIN_IN_IDLE;
            pin3_r <= fhp_pkg::PIN_IN_IDLE;
            bus1_r <= fhp_pkg::BUS_IDLE;
            bus2_r <= fhp_pkg::BUS_IDLE;
        end
        else
        begin
            pin1_r <= pin_in;
            pin2_r <= pin1_r;
            pin3_r <= pin2_r;
            bus1_r <= host_bus_in;
            bus2_r <= bus1_r;
        end
    end

    // Strobes lag the data by the same two flops, so data is settled when seen
    assign hr_act = (pin2_r.host_reset_b == fhp_pkg::LVL_TRUE); // see R01
    assign on_act = (pin2_r.host_online_b == fhp_pkg::LVL_TRUE);
    assign req_act = (pin2_r.request_b == fhp_pkg::LVL_TRUE);
    assign stb_act = (pin2_r.host_data_strobe_b == fhp_pkg::LVL_TRUE);
    assign on_fell = on_act == 1'b0 && pin3_r.host_online_b == fhp_pkg::LVL_TRUE;

    // Idle meaning of ready depends on the transfer mode
    always_comb
    begin
        if (on_act && wr_mode)
            idle_rdy = buf_free; // see R13
        else if (on_act && rd_mode)
            idle_rdy = buf_full; // see R14
        else
            idle_rdy = cmd_accept || done_r; // see R12
    end

    // Port sequencer: every byte is fully interlocked with its strobe
    always_comb
    begin
        st_nxt = st_r;
        bus_out_nxt = bus_out_r;
        cmd_byte_nxt = cmd_byte_r;
        wr_byte_nxt = wr_byte_r;
        cmd_valid_nxt = 1'b0;
        wr_valid_nxt = 1'b0;
        stat_taken_nxt = 1'b0;
        rd_taken_nxt = 1'b0;
        start_nxt = 1'b0;
        abort_nxt = on_fell; // see R03
        done_nxt = done_r;
        case (st_r)
            fhp_pkg::ST_INIT:
                if (!hr_act && !start_r && !recal_busy)
                    st_nxt = fhp_pkg::ST_IDLE;
            fhp_pkg::ST_IDLE:
                if (stat_valid && !req_act)
                begin
                    bus_out_nxt = stat_byte;
                    st_nxt = fhp_pkg::ST_ST_SET;
                end
                else if (on_act && rd_mode && rd_valid && !stb_act)
                begin
                    bus_out_nxt = rd_byte;
                    st_nxt = fhp_pkg::ST_RD_SET;
                end
                else if (on_act && wr_mode && stb_act)
                begin
                    wr_byte_nxt = bus2_r; // see R07
                    wr_valid_nxt = 1'b1;
                    st_nxt = fhp_pkg::ST_WR;
                end
                else if (req_act)
                begin
                    cmd_byte_nxt = bus2_r; // see R04
                    cmd_valid_nxt = 1'b1;
                    done_nxt = 1'b0;
                    st_nxt = fhp_pkg::ST_CMD;
                end
            fhp_pkg::ST_CMD, fhp_pkg::ST_WR, fhp_pkg::ST_REQ_END:
                if (!req_act && !stb_act)
                    st_nxt = fhp_pkg::ST_IDLE; // see R20
            fhp_pkg::ST_RD_SET:
                st_nxt = fhp_pkg::ST_RD_ACK;
            fhp_pkg::ST_RD_ACK:
                if (stb_act)
                begin
                    rd_taken_nxt = 1'b1; // see R08
                    st_nxt = fhp_pkg::ST_RD_END;
                end
            fhp_pkg::ST_RD_END:
                if (!stb_act)
                    st_nxt = fhp_pkg::ST_IDLE; // see R20
            fhp_pkg::ST_ST_SET:
                st_nxt = fhp_pkg::ST_ST_RDY;
            fhp_pkg::ST_ST_RDY:
                if (req_act)
                begin
                    stat_taken_nxt = 1'b1; // see R05
                    st_nxt = fhp_pkg::ST_REQ_END;
                end
            default:
                st_nxt = fhp_pkg::ST_INIT;
        endcase
        // Losing online mid read abandons the byte on offer
        if (!on_act && (st_r == fhp_pkg::ST_RD_SET || st_r == fhp_pkg::ST_RD_ACK))
            st_nxt = fhp_pkg::ST_IDLE; // see R03
        // Completion set wins over the clear by a new command
        if (cmd_done)
            done_nxt = 1'b1; // see R12
        if (hr_act)
        begin
            st_nxt = fhp_pkg::ST_INIT; // see R06
            done_nxt = 1'b0;
        end
        if (st_nxt == fhp_pkg::ST_INIT && st_r != fhp_pkg::ST_INIT)
            start_nxt = 1'b1; // see R19
        ready_nxt = st_nxt == fhp_pkg::ST_CMD || st_nxt == fhp_pkg::ST_ST_RDY; // see R10 see R11
        if (st_nxt == fhp_pkg::ST_IDLE)
            ready_nxt = idle_rdy;
        ack_nxt = st_nxt == fhp_pkg::ST_WR || st_nxt == fhp_pkg::ST_RD_ACK; // see R09
        dir_nxt = st_nxt == fhp_pkg::ST_RD_SET || st_nxt == fhp_pkg::ST_RD_ACK
            || st_nxt == fhp_pkg::ST_ST_SET || st_nxt == fhp_pkg::ST_ST_RDY; // see R17
        exc_nxt = exc_cond; // see R15
        drv_nxt = ~(fhp_pkg::NUM_DRIVES'(1) << drive_addr); // see R18
    end

    // Power-on starts in INIT with a recalibration already requested
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            st_r <= fhp_pkg::ST_INIT;
            start_r <= 1'b1;
            ready_r <= 1'b0;
            ack_r <= 1'b0;
            dir_r <= 1'b0;
            bus_out_r <= fhp_pkg::BUS_IDLE;
            cmd_byte_r <= fhp_pkg::BUS_IDLE;
            wr_byte_r <= fhp_pkg::BUS_IDLE;
            cmd_valid_r <= 1'b0;
            wr_valid_r <= 1'b0;
            stat_taken_r <= 1'b0;
            rd_taken_r <= 1'b0;
            abort_r <= 1'b0;
            done_r <= 1'b0;
            exc_r <= 1'b0;
            drv_r <= fhp_pkg::DRV_NONE;
        end
        else
        begin
            st_r <= st_nxt;
            start_r <= start_nxt;
            ready_r <= ready_nxt;
            ack_r <= ack_nxt;
            dir_r <= dir_nxt;
            bus_out_r <= bus_out_nxt;
            cmd_byte_r <= cmd_byte_nxt;
            wr_byte_r <= wr_byte_nxt;
            cmd_valid_r <= cmd_valid_nxt;
            wr_valid_r <= wr_valid_nxt;
            stat_taken_r <= stat_taken_nxt;
            rd_taken_r <= rd_taken_nxt;
            abort_r <= abort_nxt;
            done_r <= done_nxt;
            exc_r <= exc_nxt;
            drv_r <= drv_nxt;
        end
    end

    fhp_recal u_recal
    (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .start(start_r),
        .at_bottom_raw(at_bottom_raw),
        .at_track0_raw(at_track0_raw),
        .step_down(step_down),
        .step_up(step_up),
        .busy(recal_busy)
    );

    // Pins are driven low for true; bus enable tracks direction exactly
    assign pin_out.ack_b = ack_r ? fhp_pkg::LVL_TRUE : fhp_pkg::LVL_FALSE;
    assign pin_out.ready_b = ready_r ? fhp_pkg::LVL_TRUE : fhp_pkg::LVL_FALSE;
    assign pin_out.fmt_exception_b = exc_r ? fhp_pkg::LVL_TRUE : fhp_pkg::LVL_FALSE;
    assign pin_out.direction_b = dir_r ? fhp_pkg::LVL_TRUE : fhp_pkg::LVL_FALSE;
    assign host_bus_oe_b = dir_r ? 1'b0 : 1'b1; // see R16 see R17
    assign host_bus_out = ~bus_out_r; // see R02
    assign cmd_byte = ~cmd_byte_r;
    assign wr_byte = ~wr_byte_r;
    assign cmd_valid = cmd_valid_r;
    assign wr_valid = wr_valid_r;
    assign stat_taken = stat_taken_r;
    assign rd_taken = rd_taken_r;
    assign rw_abort = abort_r;
    assign drive_sel_b = drv_r;
    assign init_busy = (st_r == fhp_pkg::ST_INIT);

    default clocking dflt @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    a_write_ack_capture: assert property (wr_valid |-> pin_out.ack_b == 1'b0 && wr_byte == ~$past(bus2_r)) // see R09
        else $error("write byte not acknowledged at capture");
    a_cmd_ready_capture: assert property (cmd_valid |-> pin_out.ready_b == 1'b0 && $past(req_act)) // see R10
        else $error("command capture without ready");
    a_bus_dir_match: assert property (host_bus_oe_b == pin_out.direction_b) // see R16
        else $error("bus enable disagrees with direction");
    a_read_setup_ack: assert property ($fell(pin_out.ack_b) && !$past(wr_valid_nxt) |-> $past(host_bus_oe_b, 1) == 1'b0) // see R09
        else $error("read ack before bus driven");
    a_status_ready_bus: assert property ($fell(pin_out.ready_b) && st_r == fhp_pkg::ST_ST_RDY |-> $past(dir_r, 1) && dir_r) // see R11
        else $error("status ready before bus driven");
    a_exc_follows: assert property (##1 (pin_out.fmt_exception_b == !$past(exc_cond))) // see R15
        else $error("exception line does not follow condition");
    a_reset_inits: assert property (hr_act |=> init_busy ##1 (recal_busy || hr_act || init_busy)) // see R06
        else $error("host reset did not start initialisation");
    a_no_ready_init: assert property (init_busy |=> pin_out.ready_b == 1'b1 || !init_busy) // see R12
        else $error("ready asserted during initialisation");
    a_online_abort: assert property (on_fell |=> rw_abort) // see R03
        else $error("online release did not end the command");
    a_strobe_interlock: assert property (st_r == fhp_pkg::ST_WR && stb_act |=> pin_out.ack_b == 1'b0) // see R20
        else $error("ack dropped while strobe still held");
    a_drive_onehot: assert property ($past(rst_b) |-> $onehot(~drive_sel_b)) // see R18
        else $error("drive select not one-hot");

    c_cmd_xfer: cover property (cmd_valid ##[1:20] st_r == fhp_pkg::ST_IDLE);
    c_write_xfer: cover property (wr_valid ##[1:20] st_r == fhp_pkg::ST_IDLE);
    c_read_xfer: cover property (rd_taken ##[1:20] st_r == fhp_pkg::ST_IDLE);
    c_status_xfer: cover property (stat_taken ##[1:20] st_r == fhp_pkg::ST_IDLE);

endmodule

// file: test/fhpt_host_model.sv
/*
 * Host adapter model for the formatter host port: drives the control pins
 * and the host half of the two-way bus.
 * Assumes the bench calls its tasks right after a rising edge of clk_sys.
 */
`timescale 1ns/10ps
module fhpt_host_model
(
    input wire logic clk_sys,
    input fhp_pkg::fhp_pin_out_type pin_out,
    input wire logic [7:0] host_bus_out,
    input wire logic host_bus_oe_b,
    output fhp_pkg::fhp_pin_in_type pin_in,
    output logic [7:0] host_bus_in,
    output int n_late
);
    logic drv;
    logic [7:0] drv_val;

    // Wire level: a released bus floats high through the terminators
    assign host_bus_in = !host_bus_oe_b ? host_bus_out : (drv ? drv_val : fhp_pkg::BUS_IDLE);
    initial
    begin
        pin_in = fhp_pkg::PIN_IN_IDLE;
        drv = 1'b0;
        drv_val = 8'h00;
        n_late = 0;
    end

    // Bounded wait for an output pin level; a hang counts as late
    task automatic wait_pin(input int idx, input logic lvl);
        int k;
        k = 0;
        while (pin_out[idx] !== lvl && k < 40)
        begin
            @(posedge clk_sys);
            k++;
        end
        if (pin_out[idx] !== lvl)
            n_late++;
    endtask

    task automatic set_online(input logic on);
        pin_in.host_online_b <= !on;
        @(posedge clk_sys);
    endtask

    task automatic pulse_reset();
        pin_in.host_reset_b <= 1'b0;
        repeat (4) @(posedge clk_sys);
        pin_in.host_reset_b <= 1'b1;
        @(posedge clk_sys);
    endtask

    // Byte first, strobe after, strobe held until answered
    task automatic send_cmd(input logic [7:0] b, input int hold);
        drv <= 1'b1;
        drv_val <= ~b;
        @(posedge clk_sys);
        pin_in.request_b <= 1'b0;
        @(posedge clk_sys);
        wait_pin(2, 1'b0);
        repeat (hold) @(posedge clk_sys);
        pin_in.request_b <= 1'b1;
        repeat (4) @(posedge clk_sys);
        drv <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic write_byte(input logic [7:0] b, input int hold);
        drv <= 1'b1;
        drv_val <= ~b;
        @(posedge clk_sys);
        pin_in.host_data_strobe_b <= 1'b0;
        @(posedge clk_sys);
        wait_pin(3, 1'b0);
        repeat (hold) @(posedge clk_sys);
        pin_in.host_data_strobe_b <= 1'b1;
        @(posedge clk_sys);
        wait_pin(3, 1'b1);
        drv <= 1'b0;
        @(posedge clk_sys);
    endtask

    // Capture first, then strobe: the byte is taken at the answering edge
    task automatic read_byte(output logic [7:0] b);
        wait_pin(3, 1'b0);
        b = ~host_bus_in;
        pin_in.host_data_strobe_b <= 1'b0;
        @(posedge clk_sys);
        wait_pin(3, 1'b1);
        pin_in.host_data_strobe_b <= 1'b1;
        @(posedge clk_sys);
        wait_pin(0, 1'b1);
    endtask

    task automatic read_status(output logic [7:0] b);
        wait_pin(0, 1'b0);
        wait_pin(2, 1'b0);
        b = ~host_bus_in;
        pin_in.request_b <= 1'b0;
        @(posedge clk_sys);
        wait_pin(2, 1'b1);
        pin_in.request_b <= 1'b1;
        @(posedge clk_sys);
        wait_pin(0, 1'b1);
    endtask
endmodule

// file: test/tape_formatter_host_port_test.sv
/*
 * Self-checking bench for the formatter host port: the bench plays the
 * formatter core and the sensors, the host model plays the adapter.
 * Assumes the design package is compiled first.
 */
`timescale 1ns/10ps
module tape_formatter_host_port_test;
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    fhp_pkg::fhp_pin_in_type pin_in;
    fhp_pkg::fhp_pin_out_type pin_out;
    logic [7:0] host_bus_in, host_bus_out, cmd_byte, wr_byte, got;
    logic [7:0] stat_byte = 8'h00, rd_byte = 8'h00, cap_cmd, cap_wr;
    logic [3:0] drive_sel_b;
    logic [1:0] drive_addr = 2'h0;
    logic host_bus_oe_b, cmd_valid, stat_taken, wr_valid, rd_taken, rw_abort;
    logic init_busy, step_down, step_up;
    logic cmd_accept = 1'b1, cmd_done = 1'b0, stat_valid = 1'b0, wr_mode = 1'b0;
    logic buf_free = 1'b0, rd_mode = 1'b0, buf_full = 1'b0, rd_valid = 1'b0;
    logic exc_cond = 1'b0, at_bottom_raw = 1'b0, at_track0_raw = 1'b0;
    int n_mismatch = 0, checks_done = 0, n_late, n_cmd = 0, n_wr = 0, n_stat = 0, n_rd = 0, n_abort = 0;

    always #50 clk_sys = ~clk_sys;

    fhp_host_port i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .pin_in(pin_in), .pin_out(pin_out),
        .host_bus_in(host_bus_in), .host_bus_out(host_bus_out), .host_bus_oe_b(host_bus_oe_b),
        .cmd_byte(cmd_byte), .cmd_valid(cmd_valid), .cmd_accept(cmd_accept), .cmd_done(cmd_done),
        .stat_byte(stat_byte), .stat_valid(stat_valid), .stat_taken(stat_taken), .wr_mode(wr_mode),
        .buf_free(buf_free), .wr_byte(wr_byte), .wr_valid(wr_valid), .rd_mode(rd_mode),
        .buf_full(buf_full), .rd_byte(rd_byte), .rd_valid(rd_valid), .rd_taken(rd_taken),
        .rw_abort(rw_abort), .exc_cond(exc_cond), .drive_addr(drive_addr), .drive_sel_b(drive_sel_b),
        .init_busy(init_busy), .at_bottom_raw(at_bottom_raw), .at_track0_raw(at_track0_raw),
        .step_down(step_down), .step_up(step_up));

    fhpt_host_model i_host (.clk_sys(clk_sys), .pin_out(pin_out), .host_bus_out(host_bus_out),
        .host_bus_oe_b(host_bus_oe_b), .pin_in(pin_in), .host_bus_in(host_bus_in), .n_late(n_late));

    // Core side: counts pulses and drops pending levels once taken, as the core would
    always @(posedge clk_sys)
    begin
        if (cmd_valid === 1'b1)
        begin
            n_cmd++;
            cap_cmd = cmd_byte;
        end
        if (wr_valid === 1'b1)
        begin
            n_wr++;
            cap_wr = wr_byte;
        end
        if (stat_taken === 1'b1)
        begin
            n_stat++;
            stat_valid <= 1'b0;
        end
        if (rd_taken === 1'b1)
        begin
            n_rd++;
            rd_valid <= 1'b0;
        end
        if (rw_abort === 1'b1)
            n_abort++;
    end

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    // Sensors follow the stepping: bottom stop first, then track 0
    task automatic run_recal();
        int k;
        k = 0;
        while (step_down !== 1'b1 && k < 40)
        begin
            tick(1);
            k++;
        end
        chk(step_down, 1'b1);
        chk(init_busy, 1'b1);
        at_bottom_raw <= 1'b1;
        tick(6);
        chk(step_up, 1'b1);
        at_bottom_raw <= 1'b0;
        at_track0_raw <= 1'b1;
        tick(8);
        chk({step_down, step_up, init_busy}, 8'h00);
        at_track0_raw <= 1'b0;
        tick(1);
    endtask

    task automatic t_command();
        tick(3);
        chk(pin_out.ready_b, 1'b0);
        i_host.send_cmd(8'hA5, 3);
        chk(cap_cmd, 8'hA5);
        chk(8'(n_cmd), 8'h01);
        cmd_accept <= 1'b0;
        tick(4);
        chk(pin_out.ready_b, 1'b1);
        cmd_done <= 1'b1;
        tick(1);
        cmd_done <= 1'b0;
        tick(3);
        chk(pin_out.ready_b, 1'b0);
        $display("command test done");
    endtask

    task automatic t_status();
        stat_byte <= 8'h3C;
        stat_valid <= 1'b1;
        i_host.read_status(got);
        chk(got, 8'h3C);
        chk(8'(n_stat), 8'h01);
        chk({pin_out.direction_b, host_bus_oe_b}, 8'h03);
        $display("status test done");
    endtask

    task automatic t_write();
        i_host.set_online(1'b1);
        wr_mode <= 1'b1;
        buf_free <= 1'b1;
        tick(4);
        chk(pin_out.ready_b, 1'b0);
        buf_free <= 1'b0;
        tick(4);
        chk(pin_out.ready_b, 1'b1);
        i_host.write_byte(8'h81, 5);
        chk(cap_wr, 8'h81);
        i_host.write_byte(8'h01, 0);
        chk(cap_wr, 8'h01);
        chk(8'(n_wr), 8'h02);
        wr_mode <= 1'b0;
        i_host.set_online(1'b0);
        tick(6);
        $display("write test done");
    endtask

    task automatic t_read();
        i_host.set_online(1'b1);
        rd_mode <= 1'b1;
        tick(4);
        chk(pin_out.ready_b, 1'b1);
        buf_full <= 1'b1;
        tick(4);
        chk(pin_out.ready_b, 1'b0);
        rd_byte <= 8'hC3;
        rd_valid <= 1'b1;
        i_host.read_byte(got);
        chk(got, 8'hC3);
        chk(8'(n_rd), 8'h01);
        i_host.set_online(1'b0);
        tick(5);
        chk(8'(n_abort), 8'h02);
        rd_mode <= 1'b0;
        buf_full <= 1'b0;
        tick(2);
        $display("read test done");
    endtask

    task automatic t_misc();
        exc_cond <= 1'b1;
        tick(3);
        chk(pin_out.fmt_exception_b, 1'b0);
        exc_cond <= 1'b0;
        tick(3);
        chk(pin_out.fmt_exception_b, 1'b1);
        for (int d = 0; d < 4; d++)
        begin
            drive_addr <= 2'(d);
            tick(3);
            chk(8'(drive_sel_b), {4'h0, ~(4'h1 << d)});
        end
        i_host.pulse_reset();
        run_recal();
        $display("exception, drive select and host reset test done");
    endtask

    task automatic wrap_up();
        n_mismatch += n_late;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog: the tests need a few hundred cycles, this allows 20000
    initial
    begin
        #2000000;
        n_mismatch++;
        wrap_up();
    end

    initial
    begin
        tick(12);
        rst_b <= 1'b1;
        run_recal();
        $display("power-on recalibration test done");
        t_command();
        t_status();
        t_write();
        t_read();
        t_misc();
        wrap_up();
    end
endmodule
